// ### hw/ttm_regs.sv
`timescale 1ns/1ns
`include "ttm_map.svh"

// Functional notes
// [RULE_01] second tracker low half holds touched tag
// [RULE_02] third tracker low half holds touched tag
// [RULE_03] fourth tracker low half holds touched tag
// [RULE_04] fifth tracker low half holds touched tag
// [RULE_05] tracking value sits in upper half
// [RULE_06] coprocessor writes computed value into tracker
// [RULE_07] media read pointer readable, writable, reset zero
// [RULE_08] host keeps media write pointer next register
// [RULE_09] queue empty on equal pointers; advance on consume
module ttm_regs (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // ahb-lite slave
  input  wire ttm_pkg::ttm_ahb_req_t ahbReq,
  input  wire logic [31:0]          hwdata,
  output ttm_pkg::ttm_ahb_rsp_t     ahbRsp,
  // coprocessor tracker updates
  input  wire ttm_pkg::ttm_track_upd_t trackUpd,
  // media queue consumer
  input  wire logic                 mediaConsume,
  output logic                      mediaEmpty,
  output logic [31:0]               mediaReadPtr
);
  import ttm_pkg::*;

  ttm_tracker_t tracker [`TTM_TRACKERS];
  logic [31:0]  mqWrite;
  logic         wrPend;
  ttm_sel_t     wrSel;
  logic [31:0]  next_read;
  logic [31:0]  next_write;
  logic         consumeOk;
  ttm_sel_t     aSel;
  logic         aTake;
  logic [31:0]  rdWord;

  function automatic ttm_sel_t decodeSel(input logic [31:0] a);
    case (a)
      `TTM_ADDR_TRACK2,
      `TTM_ADDR_TRACK3,
      `TTM_ADDR_TRACK4,
      `TTM_ADDR_TRACK5:   decodeSel = TTM_SEL_TRACK;
      `TTM_ADDR_MQ_READ:  decodeSel = TTM_SEL_MQ_RD;
      `TTM_ADDR_MQ_WRITE: decodeSel = TTM_SEL_MQ_WR;
      default:            decodeSel = TTM_SEL_NONE;
    endcase
  endfunction

  function automatic logic [1:0] trackIdx(input logic [31:0] a);
    trackIdx = 2'(((a - `TTM_ADDR_TRACK2) >> 2));
  endfunction

  assign aTake = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
  assign aSel  = decodeSel(ahbReq.haddr);
  // only consume what the host has published
  assign consumeOk = mediaConsume && !mediaEmpty; // RULE_09

  // host write lands in the data phase; it beats a same-cycle consume
  always_comb begin
    next_read  = mediaReadPtr;
    next_write = mqWrite;
    if (consumeOk) begin
      next_read = mediaReadPtr + `TTM_MQ_STEP; // RULE_09
    end
    if (wrPend && wrSel == TTM_SEL_MQ_RD) begin
      next_read = hwdata; // RULE_07
    end
    if (wrPend && wrSel == TTM_SEL_MQ_WR) begin
      next_write = hwdata; // RULE_08
    end
  end

  // read word sampled in the address phase; pending writes are forwarded
  always_comb begin
    rdWord = 32'h0000_0000;
    case (aSel)
      TTM_SEL_TRACK: rdWord = {tracker[trackIdx(ahbReq.haddr)].track,
                               tracker[trackIdx(ahbReq.haddr)].tag}; // RULE_05
      TTM_SEL_MQ_RD: rdWord = next_read;
      TTM_SEL_MQ_WR: rdWord = next_write;
      default:       rdWord = 32'h0000_0000;
    endcase
  end

  // bus slave: zero wait states, always okay
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPend           <= 1'b0;
      wrSel            <= TTM_SEL_NONE;
      ahbRsp.hrdata    <= 32'h0000_0000;
      ahbRsp.hreadyout <= 1'b1;
      ahbRsp.hresp     <= 1'b0;
    end else begin
      // trackers are read only, so writes there are dropped
      wrPend           <= aTake && ahbReq.hwrite;
      wrSel            <= aSel;
      ahbRsp.hreadyout <= 1'b1;
      ahbRsp.hresp     <= 1'b0;
      if (aTake && !ahbReq.hwrite) begin
        ahbRsp.hrdata <= rdWord;
      end
    end
  end

  // tracker words only change by the coprocessor port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `TTM_TRACKERS; i++) begin
        tracker[i] <= `TTM_TRACK_RESET;
      end
    end else if (trackUpd.valid) begin
      tracker[trackUpd.index] <= trackUpd.data; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_06
    end
  end

  // media queue pointers and empty flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mediaReadPtr <= `TTM_MQ_READ_RESET; // RULE_07
      mqWrite      <= `TTM_MQ_WRITE_RESET;
      mediaEmpty   <= 1'b1;
    end else begin
      mediaReadPtr <= next_read;
      mqWrite      <= next_write;
      mediaEmpty   <= (next_read == next_write); // RULE_09
    end
  end

  // checks
  AST_TRACK2_TAG: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    trackUpd.valid && trackUpd.index == 2'd0 |=> tracker[0].tag == $past(trackUpd.data.tag))
    else $error("second tracker tag not stored");
  AST_TRACK3_TAG: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    trackUpd.valid && trackUpd.index == 2'd1 |=> tracker[1].tag == $past(trackUpd.data.tag))
    else $error("third tracker tag not stored");
  AST_TRACK4_TAG: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    trackUpd.valid && trackUpd.index == 2'd2 |=> tracker[2].tag == $past(trackUpd.data.tag))
    else $error("fourth tracker tag not stored");
  AST_TRACK5_TAG: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    trackUpd.valid && trackUpd.index == 2'd3 |=> tracker[3].tag == $past(trackUpd.data.tag))
    else $error("fifth tracker tag not stored");
  AST_TRACK_READ: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    aTake && !ahbReq.hwrite && aSel == TTM_SEL_TRACK
    |=> ahbRsp.hrdata[31:16] == $past(tracker[trackIdx(ahbReq.haddr)].track)
        && ahbRsp.hrdata[15:0] == $past(tracker[trackIdx(ahbReq.haddr)].tag))
    else $error("tracker read word misplaced");
  AST_TRACK_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    !trackUpd.valid |=> $stable(tracker[0]) && $stable(tracker[1]) && $stable(tracker[2]) && $stable(tracker[3]))
    else $error("tracker changed without update");
  AST_MQ_READ_WR: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    aTake && ahbReq.hwrite && aSel == TTM_SEL_MQ_RD ##1 1'b1 |=> mediaReadPtr == $past(hwdata))
    else $error("read pointer write lost");
  AST_MQ_RESET: assert property (@(posedge clk) // RULE_07
    $past(sys_rst) |-> mediaReadPtr == 32'h0000_0000)
    else $error("read pointer not zero after reset");
  AST_MQ_ADVANCE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    !(wrPend && wrSel == TTM_SEL_MQ_RD) |=> mediaReadPtr == $past(mediaReadPtr)
      + ($past(consumeOk) ? `TTM_MQ_STEP : 32'h0000_0000))
    else $error("read pointer moved wrongly");
  AST_MQ_EMPTY: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    ##1 mediaEmpty == (mediaReadPtr == mqWrite))
    else $error("empty flag disagrees with pointers");

  // bus side: the slave never stalls and never errors
  AST_RESP_OKAY: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    ahbRsp.hreadyout == 1'b1 && ahbRsp.hresp == 1'b0)
    else $error("bus response not ready and okay");
  AST_HRDATA_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    !(aTake && !ahbReq.hwrite) |=> $stable(ahbRsp.hrdata))
    else $error("read data changed without a read");
  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    aTake && !ahbReq.hwrite && aSel == TTM_SEL_NONE |=> ahbRsp.hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_RD_PTR_READ: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    aTake && !ahbReq.hwrite && aSel == TTM_SEL_MQ_RD |=> ahbRsp.hrdata == mediaReadPtr)
    else $error("read pointer read back wrong");
  AST_WR_PTR_READ: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    aTake && !ahbReq.hwrite && aSel == TTM_SEL_MQ_WR |=> ahbRsp.hrdata == mqWrite)
    else $error("write pointer read back wrong");

  // tracker words: whole word per update, cleared by reset
  AST_TRACK_WORD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    trackUpd.valid |=> tracker[$past(trackUpd.index)] == $past(trackUpd.data))
    else $error("tracker word not stored whole");
  AST_TRACK_RO: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    wrPend && wrSel == TTM_SEL_TRACK && !trackUpd.valid
    |=> $stable(tracker[0]) && $stable(tracker[1]) && $stable(tracker[2]) && $stable(tracker[3]))
    else $error("bus write reached a tracker word");
  AST_TRACK_RESET: assert property (@(posedge clk) // RULE_01
    $past(sys_rst) |-> tracker[0] == `TTM_TRACK_RESET && tracker[1] == `TTM_TRACK_RESET
      && tracker[2] == `TTM_TRACK_RESET && tracker[3] == `TTM_TRACK_RESET)
    else $error("tracker not cleared by reset");

  // media queue: a write to the read pointer beats a consume
  AST_MQ_WRITE_WR: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    aTake && ahbReq.hwrite && aSel == TTM_SEL_MQ_WR ##1 1'b1 |=> mqWrite == $past(hwdata))
    else $error("write pointer write lost");
  AST_MQ_WRITE_RESET: assert property (@(posedge clk) // RULE_09
    $past(sys_rst) |-> mqWrite == `TTM_MQ_WRITE_RESET && mediaEmpty)
    else $error("write pointer or empty flag wrong after reset");
  AST_MQ_WR_BEATS_CONSUME: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    wrPend && wrSel == TTM_SEL_MQ_RD && consumeOk |=> mediaReadPtr == $past(hwdata))
    else $error("consume overrode a read pointer write");
  AST_MQ_EMPTY_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    mediaEmpty && !(wrPend && (wrSel == TTM_SEL_MQ_RD || wrSel == TTM_SEL_MQ_WR))
    |=> $stable(mediaReadPtr) && mediaEmpty)
    else $error("empty queue moved without a pointer write");

  COV_TRACK_READ: cover property (@(posedge clk) disable iff (sys_rst)
    trackUpd.valid ##1 aTake && !ahbReq.hwrite && aSel == TTM_SEL_TRACK);
  COV_MQ_DRAIN: cover property (@(posedge clk) disable iff (sys_rst)
    !mediaEmpty ##1 consumeOk ##1 mediaEmpty);
  COV_WR_THEN_RD: cover property (@(posedge clk) disable iff (sys_rst)
    aTake && ahbReq.hwrite && aSel == TTM_SEL_MQ_WR ##1 aTake && !ahbReq.hwrite);
  COV_WR_BEATS_CONSUME: cover property (@(posedge clk) disable iff (sys_rst)
    wrPend && wrSel == TTM_SEL_MQ_RD && consumeOk);
  COV_BUS_TRACK_WRITE: cover property (@(posedge clk) disable iff (sys_rst)
    aTake && ahbReq.hwrite && aSel == TTM_SEL_TRACK);
endmodule

// ### hw/ttm_map.svh
`ifndef TTM_MAP_SVH
`define TTM_MAP_SVH

// byte addresses of the register words
`define TTM_ADDR_TRACK2     32'h0000_7004
`define TTM_ADDR_TRACK3     32'h0000_7008
`define TTM_ADDR_TRACK4     32'h0000_700c
`define TTM_ADDR_TRACK5     32'h0000_7010
`define TTM_ADDR_MQ_READ    32'h0000_7014
`define TTM_ADDR_MQ_WRITE   32'h0000_7018

// field positions inside a tracker word
`define TTM_TAG_LSB         0
`define TTM_TAG_MSB         15
`define TTM_TRACK_LSB       16
`define TTM_TRACK_MSB       31

// reset values
`define TTM_TRACK_RESET     32'h0000_0000
`define TTM_MQ_READ_RESET   32'h0000_0000
`define TTM_MQ_WRITE_RESET  32'h0000_0000

// bytes consumed from the media queue per accepted consume request
`define TTM_MQ_STEP         32'h0000_0004

// number of tracker words held here
`define TTM_TRACKERS        4

`endif

// ### hw/ttm_pkg.sv
package ttm_pkg;

  typedef struct packed {
    logic [15:0] track;
    logic [15:0] tag;
  } ttm_tracker_t;

  typedef struct packed {
    logic         valid;
    logic [1:0]   index;
    ttm_tracker_t data;
  } ttm_track_upd_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
    logic        hready;
  } ttm_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ttm_ahb_rsp_t;

  typedef enum logic [2:0] {
    TTM_SEL_NONE   = 3'b000,
    TTM_SEL_TRACK  = 3'b001,
    TTM_SEL_MQ_RD  = 3'b010,
    TTM_SEL_MQ_WR  = 3'b011
  } ttm_sel_t;

endpackage

// ### verif/ttm_host_model.sv
`timescale 1ns/1ns
module ttm_host_model (
  // clock
  input  wire logic                  clk,
  // ahb-lite master side
  input  wire ttm_pkg::ttm_ahb_rsp_t ahbRsp,
  output ttm_pkg::ttm_ahb_req_t      ahbReq,
  output logic [31:0]                hwdata
);
  import ttm_pkg::*;
  logic [31:0] addr  = '0;
  logic [1:0]  trans = '0;
  logic        wrEn  = 1'b0;
  // single slave, so its hreadyout is the bus hready
  assign ahbReq = '{haddr: addr, htrans: trans, hwrite: wrEn, hsize: 3'b010, hsel: 1'b1,
                    hready: ahbRsp.hreadyout};
  initial hwdata = '0;
  // caller enters just after a rising edge; nothing assumed about wait states
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    addr <= a;
    trans <= 2'b10;
    wrEn <= w;
    do @(posedge clk); while (ahbRsp.hreadyout !== 1'b1);
    trans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (ahbRsp.hreadyout !== 1'b1);
    q = ahbRsp.hrdata;
  endtask
endmodule

// ### verif/tb_touch_tracker_mediafifo_regs.sv
`timescale 1ns/1ns
`include "ttm_map.svh"
module tb_touch_tracker_mediafifo_regs;
  import ttm_pkg::*;
  logic           clk;
  logic           sys_rst;
  logic           mediaConsume;
  logic           mediaEmpty;
  logic [31:0]    hwdata;
  logic [31:0]    mediaReadPtr;
  logic [31:0]    q;
  ttm_ahb_req_t   ahbReq;
  ttm_ahb_rsp_t   ahbRsp;
  ttm_track_upd_t trackUpd;
  int             mismatches = 0;
  int             checkCount = 0;
  ttm_regs dut (.clk(clk), .sys_rst(sys_rst), .ahbReq(ahbReq), .hwdata(hwdata), .ahbRsp(ahbRsp),
    .trackUpd(trackUpd), .mediaConsume(mediaConsume), .mediaEmpty(mediaEmpty), .mediaReadPtr(mediaReadPtr));
  ttm_host_model host (.clk(clk), .ahbRsp(ahbRsp), .ahbReq(ahbReq), .hwdata(hwdata));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, '0, q);
    chk($sformatf("read %h", a), exp, q);
    chk("read response", 32'h0, {31'h0, ahbRsp.hresp});
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
    chk("write response", 32'h0, {31'h0, ahbRsp.hresp});
  endtask
  task automatic check_cleared;
    for (int i = 0; i < 6; i++) rd(`TTM_ADDR_TRACK2 + 4 * i, '0);
    chk("empty", 32'h1, {31'h0, mediaEmpty});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // whole run needs well under a thousand cycles
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    trackUpd = '0;
    mediaConsume = 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check_cleared();
    $display("test reset done");
    // updates on consecutive cycles, one per tracker
    for (int i = 0; i < 4; i++) begin
      trackUpd <= '{valid: 1'b1, index: 2'(i), data: '{track: 16'ha000 + 16'(i), tag: 16'h0040 + 16'(i)}};
      @(posedge clk);
    end
    trackUpd <= '0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(`TTM_ADDR_TRACK2 + 4 * i, {16'ha000 + 16'(i), 16'h0040 + 16'(i)});
    wr(`TTM_ADDR_TRACK2, 32'hffff_ffff);
    rd(`TTM_ADDR_TRACK2, 32'ha000_0040);
    rd(`TTM_ADDR_TRACK5, 32'ha003_0043);
    $display("test trackers done");
    wr(`TTM_ADDR_MQ_WRITE, 32'h0000_0010);
    wr(`TTM_ADDR_MQ_READ, 32'h0000_0008);
    rd(`TTM_ADDR_MQ_WRITE, 32'h0000_0010);
    chk("empty", '0, {31'h0, mediaEmpty});
    // third consume lands on an empty queue and must be dropped
    mediaConsume <= 1'b1;
    repeat (3) @(posedge clk);
    mediaConsume <= 1'b0;
    @(posedge clk);
    chk("read pointer", 32'h0000_0010, mediaReadPtr);
    chk("empty", 32'h1, {31'h0, mediaEmpty});
    rd(`TTM_ADDR_MQ_READ, 32'h0000_0010);
    rd(32'h0000_7020, '0);
    wr(`TTM_ADDR_MQ_WRITE, 32'h0000_0020);
    // consume runs through the write; the host write must win its cycle
    mediaConsume <= 1'b1;
    wr(`TTM_ADDR_MQ_READ, 32'h0000_0018);
    mediaConsume <= 1'b0;
    @(posedge clk);
    chk("read pointer", 32'h0000_0018, mediaReadPtr);
    chk("empty", '0, {31'h0, mediaEmpty});
    $display("test media queue done");
    // reset again in mid-run: trackers and pointers must come back cleared
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check_cleared();
    $display("test second reset done");
    conclude();
  end
endmodule
